// ---- verilog/peripheral_access_latency.sv ----
// Wait-state generator of the peripheral bus bridge
`timescale 1ns/1ps

// Notes on behaviour
// - Product organisation range: 2 cycles equal clocks, 1 to 3 when faster.
// - Random number range: 3 cycles equal clocks, 2 to 4 peripheral cycles faster.
// - Comparator and clock range: 2 cycles equal, 1 to 3 peripheral cycles faster.
// - Remote receiver and interval timer: 2 cycles equal, 1 to 3 faster.
// - Serial, timer array and converter range: 2 equal, 1 to 3 faster.
// - Flash control range: 3 system clock cycles at any clock ratio, 5 with the halfword flag.
// - Core-local controller, machine timer, debug: 2 core cycles at any clock ratio, 4 with the halfword flag.
// - Halfword serial and checksum data registers take 2 cycles more.
// - Fractional peripheral counts: truncated minimum, rounded-up maximum.
// - Counts are minimum latencies; clock source changes add more.
// - Port register reads add the programmed port read wait count.
// - Faster system clock adds at least one peripheral sync cycle.
module peripheral_access_latency
   import access_latency_pkg::*;
#(
   parameter int WAIT_W = 3,
   parameter int DIV_W = 3,
   parameter int CNT_W = 5
) (
   input wire logic CORE_CLK_I,
   input wire logic SYS_RST_I,
   input wire logic REQ_I,
   input wire logic [31:0] ADDR_I,
   input wire logic WRITE_I,
   input wire logic HALFWORD_REG_I,
   input wire logic PORT_REG_I,
   input wire logic [WAIT_W-1:0] PORT_READ_WAIT_COUNT_I,
   input wire logic [DIV_W-1:0] PCLK_DIV_I,
   output logic READY_O,
   output logic DONE_O,
   output logic ACC_ERR_O
);

   // Assertions below share the system clock and the reset
   default clocking cb @(posedge CORE_CLK_I);
   endclocking
   default disable iff (SYS_RST_I);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   localparam int MAX_TOTAL = 3 + 2 + (1 << WAIT_W);
   if (WAIT_W < 1 || DIV_W < 1) begin : g_bad_width
      $error("port wait and divider widths must be at least one");
   end
   if ((1 << CNT_W) <= MAX_TOTAL) begin : g_bad_cnt
      $error("counter too narrow for the longest access");
   end

   // ------------------------------------------------------------
   // Peripheral clock enable
   // ------------------------------------------------------------
   logic pclk_en;

   pclk_enable_divider #(
      .DIV_W(DIV_W)
   ) u_div (
      .clk_i(CORE_CLK_I),
      .rst_i(SYS_RST_I),
      .div_i(PCLK_DIV_I),
      .pclk_en_o(pclk_en)
   );

   // ------------------------------------------------------------
   // Address decode
   // ------------------------------------------------------------
   logic [NUM_RANGES-1:0] hit;
   logic [3:0] eq_masked [0:NUM_RANGES-1];
   logic [3:0] fast_masked [0:NUM_RANGES-1];

   // One comparator pair per range; ranges never overlap
   for (genvar i = 0; i < NUM_RANGES; i++) begin : g_range
      assign hit[i] = (ADDR_I >= RANGE_LO[i]) && (ADDR_I <= RANGE_HI[i]);
      assign eq_masked[i] = hit[i] ? BASE_EQUAL[i] : 4'h0;
      assign fast_masked[i] = hit[i] ? BASE_FAST_MIN[i] : 4'h0;
   end

   logic [3:0] base_eq;
   logic [3:0] base_fast;

   // Merge the one hot range counts
   always_comb begin
      base_eq = 4'h0;
      base_fast = 4'h0;
      for (int k = 0; k < NUM_RANGES; k++) begin
         base_eq = base_eq | eq_masked[k];
         base_fast = base_fast | fast_masked[k];
      end
   end

   // ------------------------------------------------------------
   // Latency selection
   // ------------------------------------------------------------
   wire mapped = |hit;
   wire sys_faster = (PCLK_DIV_I != '0);
   wire on_pclk = |(hit & RANGE_ON_PCLK);
   wire use_pclk = sys_faster && on_pclk;
   wire port_read = PORT_REG_I && !WRITE_I && hit[RNG_PORT];
   wire [CNT_W-1:0] port_extra = port_read ? CNT_W'(PORT_READ_WAIT_COUNT_I) : '0;
   wire [CNT_W-1:0] half_extra = HALFWORD_REG_I ? CNT_W'(HALFWORD_EXTRA) : '0;
   wire [CNT_W-1:0] extras = port_extra + half_extra;
   wire [CNT_W-1:0] sys_total = mapped ? CNT_W'(base_eq) + extras : CNT_W'(UNMAPPED_CYCLES);
   // Lower bound plus one sync edge keeps the wait inside min to max
   wire [CNT_W-1:0] pclk_load = CNT_W'(base_fast) + extras;
   wire [CNT_W-1:0] sys_load = sys_total - CNT_W'(MIN_SYS_CYCLES);
   wire accept = REQ_I && READY_O;

   // ------------------------------------------------------------
   // Wait state machine
   // ------------------------------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_SYS, ST_PCLK} wait_state_t;

   wait_state_t state;
   wait_state_t next_state;
   logic [CNT_W-1:0] remain;
   logic [CNT_W-1:0] next_remain;
   logic err_held;
   logic next_err_held;
   logic next_done;

   // Next state: counts end either on the system clock or on pclk edges
   always_comb begin
      next_state = state;
      next_remain = remain;
      next_err_held = err_held;
      next_done = 1'b0;
      unique case (state)
         ST_IDLE: begin
            if (accept) begin
               next_err_held = !mapped;
               if (use_pclk) begin
                  next_state = ST_PCLK;
                  next_remain = pclk_load;
               end else begin
                  next_state = ST_SYS;
                  next_remain = sys_load;
               end
            end
         end
         ST_SYS: begin
            if (remain == '0) begin
               next_state = ST_IDLE;
               next_done = 1'b1;
            end else begin
               next_remain = remain - 1'b1;
            end
         end
         ST_PCLK: begin
            if (pclk_en) begin
               if (remain == '0) begin
                  next_state = ST_IDLE;
                  next_done = 1'b1;
               end else begin
                  next_remain = remain - 1'b1;
               end
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // State registers
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         state <= ST_IDLE;
         remain <= '0;
         err_held <= 1'b0;
      end else begin
         state <= next_state;
         remain <= next_remain;
         err_held <= next_err_held;
      end
   end

   // Bus master handshake outputs
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         READY_O <= 1'b1;
         DONE_O <= 1'b0;
         ACC_ERR_O <= 1'b0;
      end else begin
         READY_O <= (next_state == ST_IDLE);
         DONE_O <= next_done;
         ACC_ERR_O <= next_done && next_err_held;
      end
   end

   // ------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------
   logic [CNT_W-1:0] lat_cnt;
   logic [CNT_W-1:0] exp_sys;
   logic [CNT_W-1:0] pclk_cnt;
   logic [CNT_W-1:0] exp_pclk;
   logic was_pclk;

   // Cycles and pclk edges seen since the request was taken
   always_ff @(posedge CORE_CLK_I) begin
      if (SYS_RST_I) begin
         lat_cnt <= '0;
         exp_sys <= '0;
         pclk_cnt <= '0;
         exp_pclk <= '0;
         was_pclk <= 1'b0;
      end else if (accept) begin
         lat_cnt <= CNT_W'(1);
         exp_sys <= sys_total;
         pclk_cnt <= '0;
         exp_pclk <= pclk_load + CNT_W'(SYNC_PCLK_CYCLES);
         was_pclk <= use_pclk;
      end else if (!READY_O) begin
         lat_cnt <= (&lat_cnt) ? lat_cnt : lat_cnt + 1'b1; // Saturates on long waits
         pclk_cnt <= pclk_cnt + CNT_W'(pclk_en);
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   sequence s_accept;
      REQ_I && READY_O;
   endsequence

   sequence s_flash_take;
      s_accept ##0 (hit[RNG_FLASH] && !HALFWORD_REG_I);
   endsequence

   sequence s_core_take;
      s_accept ##0 (hit[RNG_CORE_LOCAL] && !HALFWORD_REG_I);
   endsequence

   sequence s_equal_plain;
      s_accept ##0 (!sys_faster && !HALFWORD_REG_I);
   endsequence

   sequence s_random_equal;
      s_accept ##0 (hit[RNG_RANDOM] && !sys_faster && !HALFWORD_REG_I);
   endsequence

   a_ready_drops: assert property (s_accept |=> !READY_O)
      else $error("ready still high after a request was taken");

   a_done_with_ready: assert property (DONE_O |-> READY_O && !$past(READY_O))
      else $error("completion without a preceding wait");

   a_done_single: assert property (DONE_O |=> !DONE_O)
      else $error("completion pulse longer than one cycle");

   a_flash_three: assert property (s_flash_take |=> !DONE_O [*2] ##1 DONE_O)
      else $error("flash range access not three system cycles");

   a_core_two: assert property (s_core_take |-> ##2 DONE_O)
      else $error("core local access not two cycles");

   a_random_equal: assert property (s_random_equal |-> ##3 DONE_O)
      else $error("random range with equal clocks not three cycles");

   a_unmapped_error: assert property (s_accept ##0 !mapped |-> ##2 (DONE_O && ACC_ERR_O))
      else $error("unmapped access not refused after two cycles");

   a_sys_exact: assert property (DONE_O && !was_pclk |-> lat_cnt == exp_sys)
      else $error("system clock count differs from range count");

   a_pclk_sync: assert property (DONE_O && was_pclk |-> pclk_cnt == exp_pclk)
      else $error("peripheral edge count wrong for a faster system clock");

   a_min_latency: assert property (DONE_O |-> lat_cnt >= CNT_W'(MIN_SYS_CYCLES))
      else $error("access completed below the minimum latency");

   // Per-range counts with equal clocks; the last check adds the halfword extra
   a_product_two: assert property (s_equal_plain ##0 hit[RNG_PRODUCT_ORG]
      |=> !DONE_O ##1 DONE_O)
      else $error("product organisation access not two cycles");

   a_cmp_rtc_two: assert property (s_equal_plain ##0 hit[RNG_CMP_RTC]
      |=> !DONE_O ##1 DONE_O)
      else $error("comparator and clock access not two cycles");

   a_remote_two: assert property (s_equal_plain ##0 hit[RNG_REMOTE_TIMER]
      |=> !DONE_O ##1 DONE_O)
      else $error("remote receiver and timer access not two cycles");

   a_serial_two: assert property (s_equal_plain ##0 hit[RNG_SERIAL_ADC]
      |=> !DONE_O ##1 DONE_O)
      else $error("serial and converter access not two cycles");

   a_port_write: assert property (s_equal_plain ##0 (hit[RNG_PORT] && WRITE_I)
      |=> !DONE_O [*2] ##1 DONE_O)
      else $error("port write took the read wait count");

   a_halfword_flash: assert property (s_accept ##0 (hit[RNG_FLASH] && HALFWORD_REG_I)
      |=> !DONE_O [*4] ##1 DONE_O)
      else $error("halfword register access not two cycles longer");

   // Handshake shape
   a_err_with_done: assert property (ACC_ERR_O |-> DONE_O)
      else $error("access error pulse without completion");

   a_wait_no_done: assert property (!READY_O |-> !DONE_O)
      else $error("completion shown while the master still waits");

   a_ready_rise_done: assert property (!READY_O |=> READY_O == DONE_O)
      else $error("ready returned without a completion pulse");

endmodule

// ---- verilog/access_latency_pkg.sv ----
// Constants for the peripheral access latency logic
package access_latency_pkg;

   // ------------------------------------------------------------
   // Address ranges and their access counts
   // ------------------------------------------------------------
   localparam int NUM_RANGES = 9;

   // Range indices
   localparam int RNG_PORT = 0;
   localparam int RNG_CRC = 1;
   localparam int RNG_PRODUCT_ORG = 2;
   localparam int RNG_RANDOM = 3;
   localparam int RNG_CMP_RTC = 4;
   localparam int RNG_REMOTE_TIMER = 5;
   localparam int RNG_SERIAL_ADC = 6;
   localparam int RNG_FLASH = 7;
   localparam int RNG_CORE_LOCAL = 8;

   localparam logic [31:0] RANGE_LO [0:NUM_RANGES-1] = '{
      32'h4004_0000, 32'h4007_4000, 32'h4009_1000, 32'h4009_1100, 32'h4009_1200,
      32'h4009_2100, 32'h4009_3000, 32'h407E_0000, 32'hE200_0000};
   localparam logic [31:0] RANGE_HI [0:NUM_RANGES-1] = '{
      32'h4004_1FFF, 32'h4007_40FF, 32'h4009_10FF, 32'h4009_11FF, 32'h4009_20FF,
      32'h4009_22FF, 32'h4009_C0FF, 32'h407F_FFFF, 32'hE680_0FFF};

   // Count with equal clocks, in system clock cycles
   localparam logic [3:0] BASE_EQUAL [0:NUM_RANGES-1] = '{
      4'h3, 4'h3, 4'h2, 4'h3, 4'h2, 4'h2, 4'h2, 4'h3, 4'h2};
   // Truncated lower bound with a faster system clock, peripheral cycles
   localparam logic [3:0] BASE_FAST_MIN [0:NUM_RANGES-1] = '{
      4'h2, 4'h2, 4'h1, 4'h2, 4'h1, 4'h1, 4'h1, 4'h0, 4'h0};
   // Ranges timed on the peripheral clock (others on the system clock)
   localparam logic [NUM_RANGES-1:0] RANGE_ON_PCLK = 9'h07F;

   // ------------------------------------------------------------
   // Extras and defaults
   // ------------------------------------------------------------
   localparam logic [3:0] HALFWORD_EXTRA = 4'h2;
   localparam logic [3:0] SYNC_PCLK_CYCLES = 4'h1;
   localparam logic [3:0] UNMAPPED_CYCLES = 4'h2;
   localparam logic [3:0] MIN_SYS_CYCLES = 4'h2;

endpackage

// ---- verilog/pclk_enable_divider.sv ----
// Divider that makes the peripheral clock enable pulse
`timescale 1ns/1ps
module pclk_enable_divider #(
   parameter int DIV_W = 3
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [DIV_W-1:0] div_i,
   output logic pclk_en_o
);

   logic [DIV_W-1:0] cnt;
   wire wrap = (cnt >= div_i);

   // ------------------------------------------------------------
   // Counter: one pulse every div_i+1 cycles, every cycle at zero
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= '0;
         pclk_en_o <= 1'b0;
      end else begin
         cnt <= wrap ? '0 : cnt + 1'b1;
         pclk_en_o <= wrap;
      end
   end

endmodule

// ---- tb/cpu_bus_master.sv ----
// Behavioural CPU bus master that issues one access at a time
`timescale 1ns/1ps
module cpu_bus_master #(
   parameter int WAIT_W = 3,
   parameter int DIV_W = 3
) (
   input wire logic clk_i,
   input wire logic ready_i,
   input wire logic done_i,
   input wire logic err_i,
   output logic req_o,
   output logic [31:0] addr_o,
   output logic write_o,
   output logic halfword_o,
   output logic port_o,
   output logic [WAIT_W-1:0] wait_o,
   output logic [DIV_W-1:0] div_o
);
   // Idle bus at time zero
   initial begin
      req_o = 1'b0;
      addr_o = 32'h0000_0000;
      write_o = 1'b0;
      halfword_o = 1'b0;
      port_o = 1'b0;
      wait_o = '0;
      div_o = '0;
   end

   // ------------------------------------------------------------
   // One access, entered just after a falling edge
   // ------------------------------------------------------------
   // Hold keeps a request up with a new address while the bridge waits
   task automatic access(input logic [31:0] a, input logic w_r, input logic h,
      input logic p, input logic [WAIT_W-1:0] w, input logic [DIV_W-1:0] d,
      input logic hold, output int lat, output logic er, output logic bad);
      lat = 0;
      er = 1'b0;
      bad = 1'b0;
      req_o = 1'b1;
      addr_o = a;
      write_o = w_r;
      halfword_o = h;
      port_o = p;
      wait_o = w;
      div_o = d;
      @(posedge clk_i);
      for (int n = 1; n <= 200; n++) begin
         @(negedge clk_i);
         if (done_i === 1'b1) begin
            lat = n;
            er = err_i;
            bad = bad | (ready_i !== 1'b1);
            break;
         end
         bad = bad | (ready_i !== 1'b0) | (err_i !== 1'b0);
         if (n == 1) begin
            // Released lines show the inverse; port, wait count and divider keep the old value
            req_o = hold;
            addr_o = hold ? 32'h0000_0004 : ~a;
            write_o = ~w_r;
            halfword_o = ~h;
         end
      end
      // Lines stay as the wait left them; the next call takes over in the done cycle
   endtask
endmodule

// ---- tb/tb_peripheral_access_latency.sv ----
// Self-checking bench for the peripheral access latency logic
`timescale 1ns/1ps
module tb_peripheral_access_latency;
   import access_latency_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic req, wr, hw, pr, ready, done, aerr;
   logic [31:0] addr;
   logic [2:0] wcnt, div;
   logic [31:0] seed = 32'hA9FBFCFB;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;

   always #20 clk = ~clk;

   peripheral_access_latency peripheral_access_latency_inst (.CORE_CLK_I(clk),
      .SYS_RST_I(rst), .REQ_I(req), .ADDR_I(addr), .WRITE_I(wr), .HALFWORD_REG_I(hw),
      .PORT_REG_I(pr), .PORT_READ_WAIT_COUNT_I(wcnt), .PCLK_DIV_I(div),
      .READY_O(ready), .DONE_O(done), .ACC_ERR_O(aerr));

   cpu_bus_master cpu_bus_master_inst (.clk_i(clk), .ready_i(ready), .done_i(done),
      .err_i(aerr), .req_o(req), .addr_o(addr), .write_o(wr), .halfword_o(hw),
      .port_o(pr), .wait_o(wcnt), .div_o(div));

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] next_rand(input logic [31:0] x);
      return (x >> 1) ^ (x[0] ? 32'h8020_0003 : 32'h0000_0000);
   endfunction

   // Packs error flag, minimum and maximum latency in system cycles
   function automatic logic [16:0] expect_of(input logic [31:0] a, input logic w_r,
      input logic h, input logic p, input logic [2:0] w, input logic [2:0] d);
      int i;
      int n;
      int k;
      i = -1;
      for (int r = 0; r < NUM_RANGES; r++) begin
         if (a >= RANGE_LO[r] && a <= RANGE_HI[r]) i = r;
      end
      if (i < 0) return {1'b1, 8'h02, 8'h02};
      n = (h ? 2 : 0) + ((p && !w_r && i == RNG_PORT) ? int'(w) : 0);
      if (d != 3'h0 && RANGE_ON_PCLK[i]) begin
         // Lower bound plus one sync edge; first edge lands 1 to d+1 cycles after taking
         k = int'(BASE_FAST_MIN[i]) + n + 1;
         return {1'b0, 8'((k - 1) * (int'(d) + 1) + 2), 8'(k * (int'(d) + 1) + 1)};
      end
      n = n + int'(BASE_EQUAL[i]);
      return {1'b0, 8'(n), 8'(n)};
   endfunction

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Random direction, flags, wait count and clock ratio for one access
   task automatic run(input logic [31:0] a, input logic hold);
      logic [16:0] e;
      int lat;
      logic er;
      logic bad;
      logic [2:0] d;
      seed = next_rand(seed);
      d = seed[5] ? seed[8:6] : 3'h0;
      e = expect_of(a, seed[0], seed[9], seed[1], seed[4:2], d);
      cpu_bus_master_inst.access(a, seed[0], seed[9], seed[1], seed[4:2], d, hold,
         lat, er, bad);
      check("latency low", 32'(lat >= int'(e[15:8])), 32'h1);
      check("latency high", 32'(lat <= int'(e[7:0])), 32'h1);
      check("access error", 32'(er), 32'(e[16]));
      check("ready during wait", 32'(bad), 32'h0);
   endtask

   task automatic results;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Cuts a hang short
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         results;
      end
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      check("ready after reset", 32'(ready), 32'h1);
      check("done after reset", 32'({done, aerr}), 32'h0);
      // Both ends and two inner addresses of every range, back to back
      for (int r = 0; r < NUM_RANGES; r++) begin
         for (int j = 0; j < 4; j++) begin
            seed = next_rand(seed);
            run(j == 0 ? RANGE_LO[r] : j == 1 ? RANGE_HI[r] :
               RANGE_LO[r] + (seed & (RANGE_HI[r] - RANGE_LO[r])), 1'b0);
         end
      end
      // Gaps between ranges and outside all of them
      run(32'h4009_2300, 1'b0);
      run(32'h4009_1000 - 32'h0000_0001, 1'b0);
      run(32'hFFFF_FFFC, 1'b0);
      // Request held with new address during wait is ignored
      run(RANGE_LO[RNG_FLASH], 1'b1);
      run(RANGE_HI[RNG_CMP_RTC], 1'b1);
      for (int j = 0; j < 12; j++) begin
         run(RANGE_LO[RNG_PORT] + 32'(j), 1'b0);
      end
      results;
   end
endmodule
